// ### logic/phase_pipe_consts.vh
// Constants for the instruction phase pipeline
`ifndef PHASE_PIPE_CONSTS_VH
`define PHASE_PIPE_CONSTS_VH
`define PC_WIDTH        12
`define INSTR_WIDTH     16
`define DATA_WIDTH      8
`define PC_RESET        12'h000
// Start-up periods in system clock periods (upper of typical range)
`define WAKE_FAST_TSYS  5'h10
`define WAKE_SLOW_TSYS  5'h02
`define WAKE_CNT_WIDTH  5
// Opcode classes, top four bits of the instruction word
`define OP_NOP          4'h0
`define OP_ADD          4'h1
`define OP_SUB          4'h2
`define OP_AND          4'h3
`define OP_OR           4'h4
`define OP_XOR          4'h5
`define OP_CPL          4'h6
`define OP_RR           4'h7
`define OP_RL           4'h8
`define OP_INC          4'h9
`define OP_DEC          4'ha
`define OP_MOVA         4'hb
`define OP_MOVM         4'hc
`define OP_SZ           4'hd
`define OP_JMP          4'he
`define OP_HALT         4'hf
`endif

// ### logic/instruction_phase_pipeline.v
// Phase generator, fetch/execute pipeline, ALU and wake-up timer
`include "phase_pipe_consts.vh"

module instruction_phase_pipeline #(
   parameter PC_W   = `PC_WIDTH,
   parameter INSTR_W = `INSTR_WIDTH,
   parameter DATA_W = `DATA_WIDTH
) (
   input  wire               clk_sys,         // System clock
   input  wire               rst_n,           // Async reset, active low
   input  wire               osc_is_slow,     // 1: slow internal RC selected
   input  wire               wake_req,        // Wake-up event while halted
   input  wire [INSTR_W-1:0] prog_rdata,      // Program memory word at prog_addr
   input  wire [DATA_W-1:0]  dmem_rdata,      // Data memory read data
   output wire [3:0]         instruction_phase_clocks, // One-hot phase clocks
   output reg  [PC_W-1:0]    prog_addr,       // Program memory address
   output wire               prog_rd,         // Fetch strobe in first phase
   output reg  [7:0]         dmem_addr,       // Data memory address
   output reg  [DATA_W-1:0]  dmem_wdata,      // Data memory write data
   output reg                dmem_we,         // Data memory write strobe
   output reg  [DATA_W-1:0]  acc,             // Accumulator
   output reg                zero_flag,       // Last ALU result was zero
   output reg                carry_flag,      // Carry or borrow out
   output reg                halted           // Core halted, phases stopped
);

   // ----------------------------------------------------------------
   // Phase generator
   // ----------------------------------------------------------------
   localparam [3:0] PH1 = 4'b0001;
   localparam [3:0] PH2 = 4'b0010;
   localparam [3:0] PH3 = 4'b0100;
   localparam [3:0] PH4 = 4'b1000;

   reg [3:0]        phase_q;
   reg [3:0]        phase_d;
   reg              run_q;            // Phases advance only while running

   // One-hot ring; stalls at first phase while halted or waking
   always @* begin
      case (phase_q)
         PH1:     phase_d = run_q ? PH2 : PH1;
         PH2:     phase_d = PH3;
         PH3:     phase_d = PH4;
         PH4:     phase_d = PH1;
         default: phase_d = PH1;
      endcase
   end

   // Ring register; reset parks it at phase one so the first fetch
   // opens a full instruction cycle
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= PH1;
      end else begin
         phase_q <= phase_d;
      end
   end

   // Only one bit ever high, so phases never overlap
   // Each phase lasts one system clock; there is no stretching
   assign instruction_phase_clocks = run_q ? phase_q : 4'h0;

   // ----------------------------------------------------------------
   // Fetch and pipeline registers
   // ----------------------------------------------------------------
   // Program counter runs one word ahead of the fetch address
   reg [PC_W-1:0]    pc_q;
   reg [INSTR_W-1:0] ir_q;           // Instruction under execution
   reg               ir_valid_q;
   reg               flush_q;        // Branch dummy cycle pending

   // Phase decode shared by fetch, execute and halt logic; a parked
   // ring reads as no phase, so nothing fires while halted
   function phase_is;
      input [3:0] ph_now;
      input [3:0] ph_want;
      input       running;
      begin
         phase_is = running & (ph_now == ph_want);
      end
   endfunction

   wire ph1 = phase_is(phase_q, PH1, run_q);
   wire ph2 = phase_is(phase_q, PH2, run_q);
   wire ph3 = phase_is(phase_q, PH3, run_q);
   wire ph4 = phase_is(phase_q, PH4, run_q);

   assign prog_rd = ph1;

   wire [3:0]  op      = ir_q[INSTR_W-1:INSTR_W-4];
   wire [7:0]  operand = ir_q[7:0];
   wire        exec_ok = ir_valid_q & ~flush_q;

   // ALU over 8-bit operands; result plus carry
   // Unary classes use the memory operand only; rotates feed the carry
   function [DATA_W:0] alu;
      input [3:0]        f;
      input [DATA_W-1:0] a;
      input [DATA_W-1:0] m;
      begin
         case (f)
            `OP_ADD:  alu = {1'b0, a} + {1'b0, m};
            `OP_SUB:  alu = {1'b0, a} - {1'b0, m};
            `OP_AND:  alu = {1'b0, a & m};
            `OP_OR:   alu = {1'b0, a | m};
            `OP_XOR:  alu = {1'b0, a ^ m};
            `OP_CPL:  alu = {1'b0, ~m};
            `OP_RR:   alu = {m[0], m[0], m[DATA_W-1:1]};
            `OP_RL:   alu = {m[DATA_W-1], m[DATA_W-2:0], m[DATA_W-1]};
            `OP_INC:  alu = {1'b0, m} + {{DATA_W{1'b0}}, 1'b1};
            `OP_DEC:  alu = {1'b0, m} - {{DATA_W{1'b0}}, 1'b1};
            default:  alu = {1'b0, m};
         endcase
      end
   endfunction

   // Class decode; a flushed slot decodes as nothing
   wire [DATA_W:0] alu_out = alu(op, acc, dmem_rdata);
   wire            is_branch = exec_ok & (op == `OP_JMP);
   wire            is_skip   = exec_ok & (op == `OP_SZ) & (dmem_rdata == {DATA_W{1'b0}});
   wire            is_halt   = exec_ok & (op == `OP_HALT);
   wire            is_alu    = exec_ok & (op >= `OP_ADD) & (op <= `OP_DEC);

   // Fetch in phase one while the previous word executes
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc_q       <= `PC_RESET;
         prog_addr  <= `PC_RESET;
         ir_q       <= {INSTR_W{1'b0}};
         ir_valid_q <= 1'b0;
         flush_q    <= 1'b0;
      end else if (ph1) begin
         // Address holds a whole cycle, giving memory three phases to answer
         prog_addr  <= pc_q;
         pc_q       <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
      end else if (ph4) begin
         // Latched word becomes next instruction; overlap keeps one per cycle
         ir_q       <= prog_rdata;
         ir_valid_q <= 1'b1;
         // Taken branch: prefetched word is a dummy, target fetched next
         flush_q    <= is_branch | is_skip;
         if (is_branch) begin
            pc_q    <= ir_q[PC_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Decode and execute across phases two to four
   // ----------------------------------------------------------------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dmem_addr  <= 8'h00;
         dmem_wdata <= {DATA_W{1'b0}};
         dmem_we    <= 1'b0;
         acc        <= {DATA_W{1'b0}};
         zero_flag  <= 1'b0;
         carry_flag <= 1'b0;
      end else begin
         // Write strobe lasts one clock; memory takes it on the next edge
         dmem_we <= 1'b0;
         // Operand address settles a whole phase before the ALU reads it
         if (ph2) begin
            dmem_addr <= operand;
         end
         if (ph3 && exec_ok) begin
            // Results land in accumulator; memory written via ACC
            if (is_alu) begin
               acc        <= alu_out[DATA_W-1:0];
               carry_flag <= alu_out[DATA_W];
               zero_flag  <= (alu_out[DATA_W-1:0] == {DATA_W{1'b0}});
            end else if (op == `OP_MOVA) begin
               acc        <= dmem_rdata;
            end else if (op == `OP_MOVM) begin
               dmem_wdata <= acc;
               dmem_we    <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Halt and wake-up start-up timer
   // ----------------------------------------------------------------
   // Start-up lengths in system clock periods, sized to the counter
   localparam [`WAKE_CNT_WIDTH-1:0] WAKE_FAST = `WAKE_FAST_TSYS;
   localparam [`WAKE_CNT_WIDTH-1:0] WAKE_SLOW = `WAKE_SLOW_TSYS;

   reg [`WAKE_CNT_WIDTH-1:0]  wake_cnt_q;     // Periods left before resuming
   reg                        waking_q;       // Start-up count in progress
   // Length follows the oscillator in use when the wake event arrives;
   // the slow clock settles in far fewer of its own periods
   wire [`WAKE_CNT_WIDTH-1:0] wake_len = osc_is_slow ? WAKE_SLOW : WAKE_FAST;

   // Resume only after the full start-up period has elapsed
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run_q      <= 1'b1;
         halted     <= 1'b0;
         waking_q   <= 1'b0;
         wake_cnt_q <= {`WAKE_CNT_WIDTH{1'b0}};
      end else if (ph4 && is_halt) begin
         // Ring parks at phase one; the word fetched beside the halt
         // is kept in ir_q and runs first after wake-up
         run_q      <= 1'b0;
         halted     <= 1'b1;
      end else if (halted && !waking_q && wake_req) begin
         // Count loads once; further requests are ignored until resume
         waking_q   <= 1'b1;
         wake_cnt_q <= wake_len - 1'b1;
      end else if (waking_q) begin
         // Zero reached: the last start-up period has passed
         if (wake_cnt_q == {`WAKE_CNT_WIDTH{1'b0}}) begin
            waking_q <= 1'b0;
            halted   <= 1'b0;
            run_q    <= 1'b1;
         end else begin
            wake_cnt_q <= wake_cnt_q - 1'b1;
         end
      end
   end

endmodule // instruction_phase_pipeline

// ### testbench/phase_pipe_sva.sv
// Assertion checker for the instruction phase pipeline
module phase_pipe_sva #(
   parameter PC_W = 12
) (
   input wire logic            clk_sys,                  // Clock
   input wire logic            rst_n,                    // Reset
   input wire logic            osc_is_slow,              // Slow start-up
   input wire logic            wake_req,                 // Wake event
   input wire logic [3:0]      instruction_phase_clocks, // Phases
   input wire logic [PC_W-1:0] prog_addr,                // Fetch address
   input wire logic            prog_rd,                  // Fetch strobe
   input wire logic            dmem_we,                  // Write strobe
   input wire logic            halted                    // Halted
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Decode and execute phases follow every running fetch phase
   sequence s_exec; instruction_phase_clocks[1] ##1 instruction_phase_clocks[2] ##1 instruction_phase_clocks[3]; endsequence
   property p_onehot; $onehot0(instruction_phase_clocks); endproperty
   property p_cycle; instruction_phase_clocks[0] && !halted |=> s_exec; endproperty
   property p_fetch; prog_rd == instruction_phase_clocks[0]; endproperty
   property p_addr_hold; instruction_phase_clocks[2] || instruction_phase_clocks[3] |-> $stable(prog_addr); endproperty
   property p_we_pulse; dmem_we |=> !dmem_we; endproperty
   property p_halt_quiet; halted |-> instruction_phase_clocks == 4'h0 && !prog_rd; endproperty
   // Bound is the start-up count plus the edge that takes the request
   property p_wake_fast; halted && wake_req && !osc_is_slow |-> ##[1:17] !halted; endproperty
   property p_wake_slow; halted && wake_req && osc_is_slow |-> ##[1:3] !halted; endproperty
   property p_resume; $fell(halted) |-> instruction_phase_clocks == 4'h1; endproperty
   a_onehot: assert property (p_onehot) else $error("phases overlap");
   a_cycle: assert property (p_cycle) else $error("phase order broken");
   a_fetch: assert property (p_fetch) else $error("fetch strobe off phase");
   a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
   a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
   a_halt_quiet: assert property (p_halt_quiet) else $error("phases run while halted");
   a_wake_fast: assert property (p_wake_fast) else $error("fast wake too slow");
   a_wake_slow: assert property (p_wake_slow) else $error("slow wake too slow");
   a_resume: assert property (p_resume) else $error("resume not at phase one");
endmodule // phase_pipe_sva

bind instruction_phase_pipeline phase_pipe_sva #(.PC_W(PC_W)) u_phase_pipe_sva (.clk_sys(clk_sys), .rst_n(rst_n),
   .osc_is_slow(osc_is_slow), .wake_req(wake_req), .instruction_phase_clocks(instruction_phase_clocks),
   .prog_addr(prog_addr), .prog_rd(prog_rd), .dmem_we(dmem_we), .halted(halted));

// ### testbench/prog_mem_model.sv
// Program memory model feeding instruction words to the core
module prog_mem_model (
   input wire logic [11:0] prog_addr, // Fetch address
   output logic [15:0]     prog_rdata // Word at that address
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:4095];
   // Combinational read, so the word is settled long before phase four
   assign prog_rdata = mem[prog_addr];
endmodule // prog_mem_model

// ### testbench/instruction_phase_pipeline_tb.sv
// Self-checking testbench for the instruction phase pipeline
module instruction_phase_pipeline_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        osc_is_slow = 1'b0;
   logic        wake_req = 1'b0;
   logic [7:0]  dmem_rdata;
   logic [7:0]  dmem [0:255];
   logic [15:0] prog_rdata;
   logic [11:0] prog_addr;
   logic [7:0]  dmem_addr, dmem_wdata, acc;
   logic [3:0]  ph;
   logic        prog_rd, dmem_we, zero_flag, carry_flag, halted;
   int          fails = 0;
   int          checks_done = 0;
   // Free-running 100 MHz system clock
   always #5 clk_sys = ~clk_sys;
   instruction_phase_pipeline u_instruction_phase_pipeline (.clk_sys(clk_sys), .rst_n(rst_n),
      .osc_is_slow(osc_is_slow), .wake_req(wake_req), .prog_rdata(prog_rdata), .dmem_rdata(dmem_rdata),
      .instruction_phase_clocks(ph), .prog_addr(prog_addr), .prog_rd(prog_rd), .dmem_addr(dmem_addr),
      .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag),
      .halted(halted));
   prog_mem_model u_prog_mem_model (.prog_addr(prog_addr), .prog_rdata(prog_rdata));
   // Data memory beside the core: read settles within the phase, write lands on the strobe edge
   assign dmem_rdata = dmem[dmem_addr];
   always @(posedge clk_sys) begin
      if (dmem_we === 1'b1) dmem[dmem_addr] <= dmem_wdata;
   end
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Bounded wait, so a core that never halts cannot hang the run
   task automatic wait_halt;
      for (int i = 0; i < 300 && halted !== 1'b1; i++) @(negedge clk_sys);
      chk("halted", 16'h0001, {15'b0, halted});
      chk("phases while halted", 16'h0000, {12'b0, ph});
   endtask
   // Two adds, a jump over a third add, a store, then halt
   task automatic t_pipeline;
      wait_halt();
      chk("accumulator", 16'h000a, {8'b0, acc});
      chk("store data", 16'h000a, {8'b0, dmem_wdata});
      chk("stored word", 16'h000a, {8'b0, dmem[8'h11]});
      chk("zero flag", 16'h0000, {15'b0, zero_flag});
      chk("carry flag", 16'h0000, {15'b0, carry_flag});
   endtask
   task automatic t_wake(input logic slow, input int lo, input int hi);
      int n;
      n = 0;
      wait_halt();
      osc_is_slow = slow;
      wake_req = 1'b1;
      while (halted === 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      wake_req = 1'b0;
      chk("wake clocks in range", 16'h0001, {15'b0, n >= lo && n <= hi});
      chk("resume phase", 16'h0001, {12'b0, ph});
   endtask
   // Mid-run reset, then every ALU class except ADD, a taken skip and a load back
   task automatic t_alu;
      logic [15:0] words [0:16];
      words = '{16'h7032, 16'hc040, 16'h6030, 16'ha031, 16'h3032, 16'h5030, 16'h4032, 16'h2032, 16'hd031,
                16'h9030, 16'hc041, 16'h8032, 16'hc042, 16'hb040, 16'hc043, 16'h9030, 16'hf000};
      rst_n = 1'b0;
      for (int i = 0; i < 4096; i++) u_prog_mem_model.mem[i] = 16'h0000;
      for (int i = 0; i < 17; i++) u_prog_mem_model.mem[i] = words[i];
      dmem[8'h30] = 8'hff;
      dmem[8'h31] = 8'h00;
      dmem[8'h32] = 8'h81;
      for (int i = 8'h40; i < 8'h44; i++) dmem[i] = 8'h55;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      chk("phase at release", 16'h0001, {12'b0, ph});
      @(negedge clk_sys);
      chk("phase after first edge", 16'h0002, {12'b0, ph});
      chk("fetch address after first edge", 16'h0000, {4'b0, prog_addr});
      wait_halt();
      chk("stored rotate right", 16'h00c0, {8'b0, dmem[8'h40]});
      chk("stored logic chain", 16'h007e, {8'b0, dmem[8'h41]});
      chk("stored rotate left", 16'h0003, {8'b0, dmem[8'h42]});
      chk("stored load", 16'h00c0, {8'b0, dmem[8'h43]});
      chk("accumulator after increment", 16'h0000, {8'b0, acc});
      chk("zero flag after increment", 16'h0001, {15'b0, zero_flag});
      chk("carry flag after increment", 16'h0001, {15'b0, carry_flag});
   endtask
   // ------------------------------
   // Main sequence and watchdog
   // ------------------------------
   initial begin
      for (int i = 0; i < 256; i++) dmem[i] = 8'h05;
      for (int i = 0; i < 4096; i++) u_prog_mem_model.mem[i] = 16'h0000;
      u_prog_mem_model.mem[0] = 16'h1010;
      u_prog_mem_model.mem[1] = 16'h1010;
      u_prog_mem_model.mem[2] = 16'he020;
      u_prog_mem_model.mem[3] = 16'h1010;
      u_prog_mem_model.mem[32] = 16'hc011;
      u_prog_mem_model.mem[33] = 16'hf000;
      u_prog_mem_model.mem[34] = 16'hf000;
      u_prog_mem_model.mem[35] = 16'he023;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      t_pipeline();
      t_wake(1'b0, 16, 17);
      t_wake(1'b1, 2, 3);
      t_alu();
      conclude();
   end
   initial begin
      #20000;
      fails++;
      conclude();
   end
endmodule // instruction_phase_pipeline_tb
